// [act_pkg.sv]
// package for the converter timing control block
package act_pkg;
	// register map (byte addresses, one word each)
	localparam logic [3:0] ACT_ADDR_CTRL3  = 4'h0;
	localparam logic [3:0] ACT_ADDR_TIMING = 4'h4;
	localparam logic [3:0] ACT_ADDR_CTRL5  = 4'h8;
	localparam logic [3:0] ACT_ADDR_STATUS = 4'hC;
	// timing register fields, ctrl3 breakpoint field and reset values
	localparam int ACT_RES_BIT   = 7;
	localparam int ACT_SMP_HI    = 6;
	localparam int ACT_SMP_LO    = 5;
	localparam int ACT_PRS_HI    = 4;
	localparam int ACT_PRS_LO    = 0;
	localparam int ACT_FRZ_HI    = 1;
	localparam int ACT_FRZ_LO    = 0;
	localparam logic [7:0] ACT_TIMING_RST = 8'h05;
	localparam logic [7:0] ACT_CTRL3_RST  = 8'h00;
	// first sample phase and conversion lengths in converter clocks
	localparam logic [4:0] ACT_PHASE1_LEN = 5'h02;
	localparam logic [4:0] ACT_BITS_HI    = 5'h0A;
	localparam logic [4:0] ACT_BITS_LO    = 5'h08;
	// breakpoint behaviour encodings
	localparam logic [1:0] ACT_FRZ_CONT   = 2'h0;
	localparam logic [1:0] ACT_FRZ_FINISH = 2'h2;
	localparam logic [1:0] ACT_FRZ_NOW    = 2'h3;

	typedef enum logic [1:0] {ACT_IDLE, ACT_SAMP1, ACT_SAMP2, ACT_CONV} act_state_t;

	typedef struct packed {
		logic       cyc;
		logic       stb;
		logic       we;
		logic [3:0] sel;
		logic [3:0] adr;
		logic [31:0] dat;
	} act_wb_req_t;

	typedef struct packed {
		logic       sample;
		logic       buffered;
		logic       convert;
		logic       lowRes;
		logic       convClkTick;
		logic       seqDone;
	} act_core_t;
endpackage

// [act_timing_ctrl.sv]
// converter clock prescaler, sample timing and breakpoint control
`timescale 1ns/1ps
// Summary of operation
// R1: breakpoint 00 continues, 10 finishes conversion then halts, 11 halts immediately.
// R2: any timing register write aborts sequence, starts nothing.
// R3: bit 7 set selects 8-bit results, clear selects 10-bit.
// R4: sampling is two converter clocks buffered, then direct connection.
// R5: bits 6:5 give second sample phase 2, 4, 8 or 16 clocks.
// R6: bits 4:0 divide bus clock by twice (value plus one).
// R7: prescaler resets to 5, bus clock divided by 12.
// R8: software keeps converter clock between 500 kHz and 2 MHz.
// R9: timing register reads and writes allowed at any time.
// R10: breakpoint behaviour lives in bits 1:0 of preceding register, acts on freeze.
// R11: released freeze resumes halted conversion where it stopped.

module act_prescaler
	import act_pkg::*;
#(
	parameter int DIV_W = 5
)
(
	// clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rst,
	// divider setting
	input  wire logic [DIV_W-1:0] divisor,
	// one pulse per converter clock period
	output logic                  tick
);
	typedef struct packed {
		logic [DIV_W-1:0] cnt;
		logic             half;
		logic             tick;
	} act_div_t;

	act_div_t div_r;
	act_div_t div_nxt;
	logic     wrap;

	// >= so a lowered divisor never strands the count above it
	assign wrap = (div_r.cnt >= divisor);

	always_comb begin
		div_nxt = div_r;
		div_nxt.tick = 1'b0;
		if (wrap) begin
			div_nxt.cnt = '0;
			div_nxt.half = !div_r.half;
			// pulse on every second wrap: period is 2*(divisor+1)
			div_nxt.tick = div_r.half; // see R6
		end else begin
			div_nxt.cnt = div_r.cnt + DIV_W'(1); // see R6
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			div_r <= '0;
		end else begin
			div_r <= div_nxt;
		end
	end

	assign tick = div_r.tick;
endmodule

module act_timing_ctrl
	import act_pkg::*;
#(
	// phase counter width, holds the longest phase
	parameter int CNT_W = 5
)
(
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// wishbone slave
	input  wire logic        wbCyc,
	input  wire logic        wbStb,
	input  wire logic        wbWe,
	input  wire logic [3:0]  wbSel,
	input  wire logic [3:0]  wbAdr,
	input  wire logic [31:0] wbDatIn,
	output logic      [31:0] wbDatOut,
	output logic             wbAck,
	// debug freeze from same clock domain
	input  wire logic        freeze,
	// converter core
	output act_core_t        core
);
	// prescaler width follows the register field
	localparam int DIV_W = ACT_PRS_HI - ACT_PRS_LO + 1;
	localparam int REG_W = 8;
	localparam int BUS_W = 32;
	localparam int PAD_W = BUS_W - 4;

	typedef struct packed {
		logic [REG_W-1:0] timing;
		logic [REG_W-1:0] ctrl3;
		act_state_t       state;
		logic [CNT_W-1:0] phaseCnt;
		logic             frozen;
		logic             finishThenHalt;
		logic             done;
		logic             ack;
		logic [BUS_W-1:0] rdat;
	} act_st_t;

	act_st_t          st_r;
	act_st_t          st_nxt;

	// bus decode
	logic             access;
	logic             wrAccess;
	logic             wrTiming;
	logic             wrCtrl3;
	logic             wrStart;
	logic [REG_W-1:0] wrByte;

	// timing fields
	logic [DIV_W-1:0] divisor;
	logic [1:0]       smpSel;
	logic [CNT_W-1:0] phase1Len;
	logic [CNT_W-1:0] phase2Len;
	logic [CNT_W-1:0] convLen;
	logic [CNT_W-1:0] phaseLen;
	logic [CNT_W-1:0] cntStep;
	logic             phaseEnd;

	// freeze and sequencing
	logic [1:0]       frzMode;
	logic             convTick;
	logic             halt;
	logic             run;
	logic             busy;
	logic             sampling;
	logic [BUS_W-1:0] statusWord;
	logic [BUS_W-1:0] rdNxt;

	// ack is registered and blocks one cycle, so a held strobe is taken every second cycle
	assign access   = wbCyc && wbStb && !st_r.ack;
	assign wrAccess = access && wbWe && wbSel[0];
	assign wrTiming = wrAccess && (wbAdr == ACT_ADDR_TIMING);
	assign wrCtrl3  = wrAccess && (wbAdr == ACT_ADDR_CTRL3);
	assign wrStart  = wrAccess && (wbAdr == ACT_ADDR_CTRL5);
	assign wrByte   = wbDatIn[REG_W-1:0];

	assign frzMode   = st_r.ctrl3[ACT_FRZ_HI:ACT_FRZ_LO]; // see R10
	assign divisor   = st_r.timing[ACT_PRS_HI:ACT_PRS_LO]; // see R6
	assign smpSel    = st_r.timing[ACT_SMP_HI:ACT_SMP_LO]; // see R5
	assign phase1Len = CNT_W'(ACT_PHASE1_LEN); // see R4
	// second phase: 2 shifted left by the field, so 2, 4, 8 or 16
	assign phase2Len = phase1Len << smpSel; // see R5
	assign convLen   = st_r.timing[ACT_RES_BIT] ? CNT_W'(ACT_BITS_LO) // see R3
		: CNT_W'(ACT_BITS_HI);
	assign busy      = (st_r.state != ACT_IDLE);
	assign sampling  = (st_r.state == ACT_SAMP1) || (st_r.state == ACT_SAMP2);
	// one shared incrementer for every phase
	assign cntStep   = st_r.phaseCnt + CNT_W'(1);

	// divider runs through freeze so the converter clock stays steady
	act_prescaler #(
		.DIV_W(DIV_W)
	) prescaler (
		.clk_sys(clk_sys),
		.rst(rst),
		.divisor(divisor),
		.tick(convTick)
	);

	// freeze; reserved 01 acts like continue
	always_comb begin
		halt = 1'b0;
		if (freeze) begin
			unique case (frzMode)
				ACT_FRZ_NOW:    halt = 1'b1; // see R1
				ACT_FRZ_FINISH: halt = st_r.finishThenHalt; // see R1
				default:        halt = 1'b0;
			endcase
		end
		// only the sequence holds its place, count and state kept
		run = convTick && !halt; // see R11
	end

	always_comb begin
		unique case (st_r.state)
			ACT_IDLE:  phaseLen = phase1Len;
			ACT_SAMP1: phaseLen = phase1Len; // see R4
			ACT_SAMP2: phaseLen = phase2Len; // see R5
			ACT_CONV:  phaseLen = convLen; // see R3
		endcase
		phaseEnd = (st_r.phaseCnt == phaseLen - CNT_W'(1));
	end

	assign statusWord = {
		PAD_W'(0),
		st_r.frozen,
		busy,
		st_r.state
	};

	always_comb begin
		st_nxt = st_r;
		st_nxt.ack = access;
		st_nxt.done = 1'b0;
		st_nxt.frozen = halt;
		st_nxt.rdat = rdNxt;

		// flag clears once freeze is gone
		if (!freeze) begin
			st_nxt.finishThenHalt = 1'b0; // see R11
		end

		unique case (st_r.state)
			ACT_IDLE: begin
				st_nxt.phaseCnt = '0;
				if (wrStart) begin
					st_nxt.state = ACT_SAMP1;
				end
			end

			ACT_SAMP1: begin
				if (run && phaseEnd) begin
					st_nxt.phaseCnt = '0;
					st_nxt.state = ACT_SAMP2; // see R4
				end else if (run) begin
					st_nxt.phaseCnt = cntStep;
				end
			end

			ACT_SAMP2: begin
				if (run && phaseEnd) begin
					st_nxt.phaseCnt = '0;
					st_nxt.state = ACT_CONV; // see R4
				end else if (run) begin
					st_nxt.phaseCnt = cntStep; // see R5
				end
			end

			ACT_CONV: begin
				if (run && phaseEnd) begin
					st_nxt.phaseCnt = '0;
					st_nxt.done = 1'b1;
					st_nxt.state = ACT_IDLE;
					// finished under freeze: hold off until release
					st_nxt.finishThenHalt = freeze; // see R1
				end else if (run) begin
					st_nxt.phaseCnt = cntStep; // see R3
				end
			end
		endcase

		// register writes; accepted in any state
		if (wrTiming) begin
			st_nxt.timing = wrByte; // see R9
		end
		if (wrCtrl3) begin
			st_nxt.ctrl3 = wrByte; // see R10
		end

		// abort wins over a start in the same cycle, no stale count left
		if (wrTiming) begin
			st_nxt.state = ACT_IDLE; // see R2
			st_nxt.phaseCnt = '0;
			st_nxt.finishThenHalt = 1'b0;
		end
	end

	// unmapped and start addresses read zero
	always_comb begin
		rdNxt = '0;
		unique case (wbAdr)
			ACT_ADDR_CTRL3:  rdNxt = BUS_W'(st_r.ctrl3);
			ACT_ADDR_TIMING: rdNxt = BUS_W'(st_r.timing); // see R9
			ACT_ADDR_STATUS: rdNxt = statusWord;
			default:         rdNxt = '0;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st_r.timing <= ACT_TIMING_RST; // see R7
			st_r.ctrl3 <= ACT_CTRL3_RST;
			st_r.state <= ACT_IDLE;
			st_r.phaseCnt <= '0;
			st_r.frozen <= 1'b0;
			st_r.finishThenHalt <= 1'b0;
			st_r.done <= 1'b0;
			st_r.ack <= 1'b0;
			st_r.rdat <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// bus answer
	assign wbAck    = st_r.ack;
	assign wbDatOut = st_r.rdat;

	// sample phases
	assign core.sample      = sampling;
	assign core.buffered    = (st_r.state == ACT_SAMP1); // see R4

	// conversion and clocking
	assign core.convert     = (st_r.state == ACT_CONV);
	assign core.lowRes      = st_r.timing[ACT_RES_BIT]; // see R3
	assign core.convClkTick = convTick;
	assign core.seqDone     = st_r.done;
endmodule

// [act_chk.sv]
// checker on the timing control ports
`timescale 1ns/1ps
module act_chk
	import act_pkg::*;
(
	// clock, reset
	input logic	clk_sys,
	input logic	rst,
	// bus
	input logic	wbCyc,
	input logic	wbStb,
	input logic	wbWe,
	input logic [3:0]	wbSel,
	input logic [3:0]	wbAdr,
	input logic [31:0]	wbDatIn,
	input logic [31:0]	wbDatOut,
	input logic	wbAck,
	// core
	input logic	freeze,
	input act_core_t	core
);
	wire tk = wbCyc && wbStb && !wbAck && wbSel[0];
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence wrTim;
		tk && wbWe && wbAdr == ACT_ADDR_TIMING;
	endsequence
	ack_pulse_a: assert property (wbAck |=> !wbAck) else $error("long ack");
	ack_answer_a: assert property (tk |=> wbAck) else $error("no ack");
	abort_idle_a: assert property (wrTim |=> !core.sample && !core.convert)
		else $error("no abort");
	res_follow_a: assert property (wrTim |=> core.lowRes == $past(wbDatIn[7]))
		else $error("bad resolution");
	buf_first_a: assert property (core.buffered |-> core.sample && !core.convert)
		else $error("bad phase");
	conv_after_a: assert property ($rose(core.convert) |-> $past(core.sample))
		else $error("bad order");
	done_conv_a: assert property (core.seqDone |-> $past(core.convert))
		else $error("stray done");
	tick_gap_a: assert property (core.convClkTick |=> !core.convClkTick)
		else $error("tick too fast");
endmodule
bind act_timing_ctrl act_chk chk (.*);

// [act_core_model.sv]
// converter core model counting bus clocks in phase two and in conversion
`timescale 1ns/1ps
module act_core_model
	import act_pkg::*;
(
	// controller side
	input logic	clk_sys,
	input act_core_t	core,
	// clocks in phase two and in conversion
	output int	p2,
	output int	cv
);
	// cleared while idle so each start measures one sequence
	wire idle = !core.sample && !core.convert;
	always_ff @(posedge clk_sys) begin
		p2 <= idle ? 0 : p2 + int'(core.sample && !core.buffered);
		cv <= idle ? 0 : cv + int'(core.convert);
	end
endmodule

// [adc_clock_sample_timing_ctrl_tb.sv]
// bench for the timing control block
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; $display("BAD %s exp %0h got %0h", n, e, g); end end
module adc_clock_sample_timing_ctrl_tb
	import act_pkg::*;
;
	logic	clk_sys = 0, rst = 1, wbCyc = 0, wbStb = 0, wbWe = 0, freeze = 0, wbAck, g;
	logic [3:0]	wbSel = '0, wbAdr = '0;
	logic [31:0]	wbDatIn = '0, wbDatOut, rd;
	act_core_t	core;
	int	errors = 0, cmp_count = 0, p2, cv, n;
	always #2.5 clk_sys = ~clk_sys;
	act_timing_ctrl dut (.*);
	act_core_model model (.clk_sys, .core, .p2, .cv);
	task complete_run;
		$display("compares %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task wb(input logic w, input logic [3:0] a, input logic [7:0] d);
		int k;
		@(posedge clk_sys);
		{wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatIn} <= {2'h3, w, a, 4'h1, 24'h0, d};
		for (k = 0; k < 20; k++) begin
			@(negedge clk_sys);
			if (wbAck === 1'b1)
				break;
		end
		rd = wbDatOut;
		@(posedge clk_sys);
		{wbCyc, wbStb} <= 2'h0;
		if (k == 20) begin
			errors++;
			complete_run;
		end
	endtask
	task wd(input int lim);
		g = 0;
		for (int k = 0; k < lim && !g; k++) begin
			@(negedge clk_sys);
			g = core.seqDone;
		end
	endtask
	initial begin
		repeat (4) @(posedge clk_sys);
		rst <= 0;
		wb(0, ACT_ADDR_TIMING, 8'h00);
		`CHK("reset", 32'h5, rd)
		for (n = 0; n < 8; n++) begin
			wb(1, ACT_ADDR_TIMING, {n[2], n[1:0], 3'h0, n[1:0]});
			wb(0, ACT_ADDR_TIMING, 8'h00);
			`CHK("readback", {24'h0, n[2], n[1:0], 3'h0, n[1:0]}, rd)
			wb(1, ACT_ADDR_CTRL5, 8'h00);
			wd(1000);
			`CHK("phase2", (2 << n[1:0]) * 2 * (n[1:0] + 1), p2)
			`CHK("convert", (n[2] ? 8 : 10) * 2 * (n[1:0] + 1), cv)
		end
		$display("timing test done");
		wb(1, ACT_ADDR_CTRL5, 8'h00);
		wb(1, ACT_ADDR_TIMING, 8'h03);
		wb(0, ACT_ADDR_STATUS, 8'h00);
		`CHK("abort", 32'h0, rd)
		wd(300);
		`CHK("restart", 1'b0, g)
		$display("abort test done");
		for (n = 0; n < 4; n++) begin
			wb(1, ACT_ADDR_CTRL3, 8'(n));
			wb(1, ACT_ADDR_CTRL5, 8'h00);
			freeze <= 1;
			wd(300);
			`CHK("frozen", n != 3, g)
			@(posedge clk_sys);
			freeze <= 0;
			wd(300);
			`CHK("resume", n == 3, g)
		end
		$display("freeze test done");
		complete_run;
	end
endmodule
